// >>> src/mcu_clock_output_pkg.sv
/*
 * Shared constants and types for the microcontroller clock output block:
 * register indices, field layout, reset value, clock tail lengths and the
 * divider table for the crystal-derived frequencies.
 * Assumes a crystal nominally at the highest selectable frequency,
 * so every divided rate is a whole number of crystal half-periods.
 */
`default_nettype none

package mcu_clock_output_pkg;

    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned REG_W      = 8;

    // register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] CTRL_INDEX   = 8'h0a;
    localparam logic [ADDR_W-1:0] STATUS_INDEX = 8'h0b;
    localparam int unsigned       INDEX_SHIFT  = 2;

    localparam logic [REG_W-1:0]  CTRL_RESET   = 8'h0b;
    localparam logic [REG_W-1:0]  CTRL_WMASK   = 8'h3f;

    localparam int unsigned MCLK_LSB  = 0;
    localparam int unsigned MCLK_W    = 3;
    localparam int unsigned ENLFC_BIT = 3;
    localparam int unsigned CLKT_LSB  = 4;
    localparam int unsigned CLKT_W    = 2;

    localparam logic [MCLK_W-1:0] MCLK_LF = 3'h7;

    localparam int unsigned TAIL_W = 10;
    localparam logic [TAIL_W-1:0] TAIL_NONE = 10'h000;
    localparam logic [TAIL_W-1:0] TAIL_128  = 10'h080;
    localparam logic [TAIL_W-1:0] TAIL_256  = 10'h100;
    localparam logic [TAIL_W-1:0] TAIL_512  = 10'h200;

    // output period counted in crystal half-periods (both edges)
    localparam int unsigned PER_W = 7;
    localparam logic [PER_W-1:0] PER_30M = 7'h02;
    localparam logic [PER_W-1:0] PER_15M = 7'h04;
    localparam logic [PER_W-1:0] PER_10M = 7'h06;
    localparam logic [PER_W-1:0] PER_4M  = 7'h0f;
    localparam logic [PER_W-1:0] PER_3M  = 7'h14;
    localparam logic [PER_W-1:0] PER_2M  = 7'h1e;
    localparam logic [PER_W-1:0] PER_1M  = 7'h3c;

    typedef enum logic [1:0]
    {
        ST_PARK = 2'b00,
        ST_ARM  = 2'b01,
        ST_RUN  = 2'b11,
        ST_TAIL = 2'b10
    } out_state_t;

    function automatic logic [PER_W-1:0] div_period(input logic [MCLK_W-1:0] sel);
        logic [PER_W-1:0] p;
        p = PER_1M;
        unique case (sel)
            3'h0:    p = PER_30M;
            3'h1:    p = PER_15M;
            3'h2:    p = PER_10M;
            3'h3:    p = PER_4M;
            3'h4:    p = PER_3M;
            3'h5:    p = PER_2M;
            3'h6:    p = PER_1M;
            3'h7:    p = PER_1M;
        endcase
        return p;
    endfunction

    function automatic logic [TAIL_W-1:0] tail_len(input logic [CLKT_W-1:0] code);
        logic [TAIL_W-1:0] t;
        t = TAIL_NONE;
        unique case (code)
            2'h0:    t = TAIL_NONE;
            2'h1:    t = TAIL_128;
            2'h2:    t = TAIL_256;
            2'h3:    t = TAIL_512;
        endcase
        return t;
    endfunction

endpackage

`default_nettype wire

// >>> src/xtal_divider.sv
/*
 * Free-running divider of the synchronised crystal level. Counts both crystal
 * edges and holds the output high for the first half of each period.
 * Assumes xtal_lvl is already synchronised to pclk and that sel only changes
 * while the caller keeps the divided clock away from the pin.
 */
`default_nettype none

module xtal_divider
    import mcu_clock_output_pkg::*;
(
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 xtal_lvl,
    input  wire logic [mcu_clock_output_pkg::MCLK_W-1:0] sel,
    output logic                                      div_lvl
);

    logic              xtal_prev_r;
    logic [MCLK_W-1:0] sel_prev_r;
    logic [PER_W-1:0]  cnt_r;
    logic [PER_W-1:0]  cnt_nxt;
    logic [PER_W-1:0]  period;
    logic              edge_seen;
    logic              restart;

    assign period    = div_period(sel);
    assign edge_seen = xtal_lvl ^ xtal_prev_r;
    assign restart   = sel != sel_prev_r;

    always_comb
    begin
        cnt_nxt = cnt_r;
        // a new setting parks the count at the end of a low phase, so the first high phase is whole
        if (restart)
            cnt_nxt = period - 7'h01;
        else if (edge_seen)
        begin
            // a count left beyond a new, shorter period wraps rather than runs away
            if (cnt_r >= period - 7'h01)
                cnt_nxt = 7'h00;
            else
                cnt_nxt = cnt_r + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xtal_prev_r <= 1'b0;
            sel_prev_r  <= CTRL_RESET[MCLK_LSB +: MCLK_W];
        end
        else
        begin
            xtal_prev_r <= xtal_lvl;
            sel_prev_r  <= sel;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r   <= 7'h00;
            div_lvl <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            div_lvl <= (cnt_nxt < (period >> 1));
        end
    end

endmodule

`default_nettype wire

// >>> src/mcu_clock_output.sv
/*
 * Microcontroller clock output: an APB-programmed clock on the output pin,
 * either a division of the crystal or the low-frequency clock, with sleep
 * handling, clock tail and interrupt hold-off.
 * Assumes crystal and low-frequency clocks arrive as pin levels well below
 * half of pclk; sleep request and interrupt-pending come from pclk logic.
 */
// The implementer's own choice: the APB interface to the registers.
// Behaviour
// RQ1: three-bit selector picks 30,15,10,4,3,2,1 MHz or 32.768 kHz output.
// RQ2: all rates but the lowest divide the crystal; lowest uses low-frequency input.
// RQ3: after reset the control register holds 0Bh and the pin carries the clock.
// RQ4: sleep with low-frequency enable set outputs 32.768 kHz whatever the selector.
// RQ5: awake states output the selected rate; switch to low frequency only in sleep.
// RQ6: crystal oscillator is switched off while asleep.
// RQ7: sleep with low-frequency enable clear stops the clock output.
// RQ8: before stopping, emit 0, 128, 256 or 512 extra cycles from a 2-bit field.
// RQ9: while an interrupt is pending the clock keeps running in any commanded mode.
// RQ10: mode change and crystal shutdown complete only after the interrupt is read.
// RQ11: source switches, start and stop never truncate a high or low phase.
`default_nettype none

module mcu_clock_output
    import mcu_clock_output_pkg::*;
(
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [mcu_clock_output_pkg::ADDR_W-1:0] paddr,
    input  wire logic [mcu_clock_output_pkg::DATA_W-1:0] pwdata,
    output logic      [mcu_clock_output_pkg::DATA_W-1:0] prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic                                 xtal_clk_in,
    input  wire logic                                 lf_clk_in,
    input  wire logic                                 sleep_cmd,
    input  wire logic                                 irq_pending,
    output logic                                      clock_output_pin,
    output logic                                      xtal_osc_en,
    output logic                                      sleep_entered
);

    localparam int unsigned SYNC_N = 2;

    logic [SYNC_N-1:0] meta_r;
    logic [SYNC_N-1:0] sync_r;
    logic              xtal_s;
    logic              lf_s;

    logic [REG_W-1:0]  ctrl_r;
    logic [MCLK_W-1:0] mclk;
    logic              enlfc;
    logic [CLKT_W-1:0] clkt;

    logic              sleep_eff_r;
    logic              sleep_prev_r;
    logic [TAIL_W-1:0] tail_left_r;

    out_state_t        state_r;
    out_state_t        state_nxt;
    logic              src_lf_r;
    logic [MCLK_W-1:0] sel_r;

    logic              div_lvl;
    logic              div_prev_r;
    logic              lf_prev_r;
    logic              lvl_cur;
    logic              rise_cur;
    logic              fall_cur;

    logic              tgt_run;
    logic              tgt_lf;
    logic              change;
    logic              xtal_used;
    logic              settled;

    logic              setup_ph;
    logic              access_ph;
    logic              hit_ctrl;
    logic              hit_status;
    logic [REG_W-1:0]  status_w;

    // registers sit on word boundaries; the index is scaled to a byte address
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'(idx << INDEX_SHIFT);
        return a == byte_addr;
    endfunction

    // both clocks are pin levels; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 2'h0;
            sync_r <= 2'h0;
        end
        else
        begin
            meta_r <= {lf_clk_in, xtal_clk_in};
            sync_r <= meta_r;
        end
    end

    assign xtal_s = sync_r[0];
    assign lf_s   = sync_r[1];

    assign mclk   = ctrl_r[MCLK_LSB +: MCLK_W];
    assign enlfc  = ctrl_r[ENLFC_BIT];
    assign clkt   = ctrl_r[CLKT_LSB +: CLKT_W];

    // APB slave: zero-wait, one access cycle, pready registered from the setup cycle
    assign setup_ph   = psel & ~penable;
    assign access_ph  = psel & penable & pready;
    assign hit_ctrl   = addr_hit(paddr, CTRL_INDEX);
    assign hit_status = addr_hit(paddr, STATUS_INDEX);

    // status snapshot: tail high bits, state, source, pin, crystal enable, sleep done
    assign status_w = {tail_left_r[TAIL_W-1:TAIL_W-2], state_r, src_lf_r,
                       clock_output_pin, xtal_osc_en, sleep_entered};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit_ctrl & ~hit_status;
            prdata  <= 32'h0;
            if (setup_ph && !pwrite)
            begin
                if (hit_ctrl)
                    prdata <= {24'h0, ctrl_r};
                else if (hit_status)
                    prdata <= {24'h0, status_w};
            end
        end
    end

    // bits above the tail field are not stored and read back as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= CTRL_RESET; // RQ3
        else if (access_ph && pwrite && hit_ctrl)
            ctrl_r <= pwdata[REG_W-1:0] & CTRL_WMASK;
    end

    // sleep counts only once no interrupt is pending; a new interrupt wakes the clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_eff_r  <= 1'b0;
            sleep_prev_r <= 1'b0;
        end
        else
        begin
            sleep_eff_r  <= sleep_cmd & ~irq_pending; // RQ9 RQ10
            sleep_prev_r <= sleep_eff_r;
        end
    end

    xtal_divider u_div
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .xtal_lvl (xtal_s),
        .sel      (sel_r),
        .div_lvl  (div_lvl)
    ); // RQ2

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_prev_r <= 1'b0;
            lf_prev_r  <= 1'b0;
        end
        else
        begin
            div_prev_r <= div_lvl;
            lf_prev_r  <= lf_s;
        end
    end

    // edges are taken per source so a switch never fakes a rising edge
    assign lvl_cur  = src_lf_r ? lf_s : div_lvl; // RQ2
    assign rise_cur = src_lf_r ? (lf_s & ~lf_prev_r) : (div_lvl & ~div_prev_r);
    assign fall_cur = src_lf_r ? (~lf_s & lf_prev_r) : (~div_lvl & div_prev_r);

    // targets: whether the pin should run, and from which source
    assign tgt_run = ~sleep_eff_r | enlfc; // RQ7
    assign tgt_lf  = sleep_eff_r | (mclk == MCLK_LF); // RQ4 RQ5
    assign change  = ~tgt_run | (tgt_lf != src_lf_r) | (~src_lf_r & (mclk != sel_r)); // RQ1
    // parking lasts until the new source and setting have reached the divider
    assign settled = (src_lf_r == (tgt_lf & tgt_run)) && (sel_r == mclk);

    // tail loaded when sleep takes effect with the clock to be stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tail_left_r <= TAIL_NONE;
        else if (sleep_eff_r && !sleep_prev_r)
            tail_left_r <= enlfc ? TAIL_NONE : tail_len(clkt); // RQ8
        else if (!sleep_eff_r)
            tail_left_r <= TAIL_NONE;
        else if (state_r == ST_TAIL && rise_cur && tail_left_r != TAIL_NONE)
            tail_left_r <= tail_left_r - 10'h001; // RQ8
    end

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_PARK:
            begin
                // a rise left over from the old setting must not start the pin
                if ((tgt_run || tail_left_r != TAIL_NONE) && settled)
                    state_nxt = ST_ARM; // RQ11
            end
            ST_ARM:
            begin
                if (change && !(tail_left_r != TAIL_NONE && !tgt_run))
                    state_nxt = ST_PARK;
                else if (rise_cur)
                    state_nxt = ST_RUN; // RQ11
            end
            ST_RUN:
            begin
                if (change)
                    state_nxt = ST_TAIL;
            end
            ST_TAIL:
            begin
                if (!change)
                    state_nxt = ST_RUN;
                else if (fall_cur && (tgt_run || tail_left_r == TAIL_NONE))
                    state_nxt = ST_PARK; // RQ8 RQ11
            end
        endcase
    end

    // the state code is shown in the status word, so its encoding is visible to software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_PARK;
        else
            state_r <= state_nxt;
    end

    // source and divider setting change only while the pin is parked low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_lf_r <= 1'b0;
            sel_r    <= CTRL_RESET[MCLK_LSB +: MCLK_W];
        end
        else if (state_r == ST_PARK)
        begin
            src_lf_r <= tgt_lf & tgt_run; // RQ4 RQ11
            sel_r    <= mclk; // RQ1
        end
    end

    // the pin follows the source only from a whole high phase to a whole low phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_output_pin <= 1'b0;
        else if (state_nxt == ST_RUN || state_nxt == ST_TAIL)
            clock_output_pin <= lvl_cur; // RQ5 RQ11
        else
            clock_output_pin <= 1'b0; // RQ7
    end

    assign xtal_used = ~src_lf_r & (state_r != ST_PARK);

    // the crystal stays on while it still feeds the pin, so a tail or a switch can finish
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xtal_osc_en <= 1'b1;
        else
            xtal_osc_en <= ~sleep_eff_r | xtal_used; // RQ6 RQ10
    end

    // mode change reported complete once the crystal is really off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_entered <= 1'b0;
        else
            sleep_entered <= sleep_eff_r & ~xtal_osc_en; // RQ10
    end

endmodule

`default_nettype wire

// >>> tb/mcu_clock_output_asserts.sv
/*
 * Checker for the microcontroller clock output block: bus handshake,
 * phase lengths of the output clock and the sleep sequencing.
 * Assumes it is bound to mcu_clock_output and sees only its ports.
 */
`default_nettype none

module mcu_clock_output_asserts
(
    input wire logic                                      pclk,
    input wire logic                                      presetn,
    input wire logic                                      psel,
    input wire logic                                      penable,
    input wire logic [mcu_clock_output_pkg::ADDR_W-1:0]   paddr,
    input wire logic [mcu_clock_output_pkg::DATA_W-1:0]   prdata,
    input wire logic                                      pready,
    input wire logic                                      pslverr,
    input wire logic                                      sleep_cmd,
    input wire logic                                      irq_pending,
    input wire logic                                      clock_output_pin,
    input wire logic                                      xtal_osc_en,
    input wire logic                                      sleep_entered
);
    import mcu_clock_output_pkg::*;

    logic       last_r;
    logic [2:0] run_r;

    // run length of the current pin level, saturating; reset as long so no false short phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_r <= 1'b0;
            run_r  <= 3'h7;
        end
        else
        begin
            last_r <= clock_output_pin;
            run_r  <= (clock_output_pin != last_r) ? 3'h1 : ((run_r == 3'h7) ? run_r : run_r + 3'h1);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    pready_access_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup cycle");
    err_unmapped_a: assert property (pslverr |-> pready && paddr != 8'h28 && paddr != 8'h2c)
        else $error("pslverr on mapped address");
    rdata_idle_a: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero outside access");
    phase_len_a: assert property (clock_output_pin != last_r |-> run_r >= 3'h4)
        else $error("truncated clock phase");
    asleep_xtal_a: assert property (sleep_entered |-> !xtal_osc_en)
        else $error("crystal on while asleep");
    irq_hold_a: assert property (irq_pending [*5] |-> xtal_osc_en && !sleep_entered)
        else $error("clock not held by pending interrupt");
    awake_a: assert property (!sleep_cmd [*5] |-> xtal_osc_en && !sleep_entered)
        else $error("asleep without sleep command");
    xtal_stop_a: assert property ($fell(xtal_osc_en) |-> $past(sleep_cmd, 2) && !$past(irq_pending, 2))
        else $error("crystal stopped without cause");
endmodule

bind mcu_clock_output mcu_clock_output_asserts i_asserts
(
    .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .sleep_cmd, .irq_pending, .clock_output_pin, .xtal_osc_en, .sleep_entered
);

`default_nettype wire

// >>> tb/mcu_model.sv
/*
 * Model of the microcontroller running from the output clock: measures the
 * period in pclk cycles, counts rising edges and reads a pending interrupt.
 * Assumes pclk is the bench's reference clock.
 */
`default_nettype none

module mcu_model
#(
    parameter int READ_EDGES = 16
)
(
    input  wire logic        pclk,
    input  wire logic        mcu_clk,
    input  wire logic        irq_pending,
    output logic             irq_read,
    output logic [15:0]      period,
    output logic [15:0]      edge_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        prev_r;
    logic [15:0] cyc_r;
    logic [7:0]  seen_r;

    initial
    begin
        prev_r   = 1'b0;
        cyc_r    = 16'h0;
        seen_r   = 8'h0;
        period   = 16'h0;
        edge_cnt = 16'h0;
    end

    always @(posedge pclk)
    begin
        prev_r <= mcu_clk;
        cyc_r  <= cyc_r + 16'h1;
        if (mcu_clk && !prev_r)
        begin
            period   <= cyc_r;
            cyc_r    <= 16'h1;
            edge_cnt <= edge_cnt + 16'h1;
        end
    end

    // the read runs on our own clock, so a stopped clock leaves it pending for good
    always @(posedge mcu_clk or negedge irq_pending)
    begin
        if (!irq_pending)
            seen_r <= 8'h0;
        else if (seen_r != 8'(READ_EDGES))
            seen_r <= seen_r + 8'h1;
    end

    assign irq_read = (seen_r == 8'(READ_EDGES));
endmodule

`default_nettype wire

// >>> tb/mcu_clock_output_tb.sv
/*
 * Bench for the microcontroller clock output block: APB register access,
 * every rate, sleep with and without low-frequency clock, tail, interrupt hold.
 * Assumes the crystal stands still while its enable is low.
 */
`default_nettype none

module mcu_clock_output_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcu_clock_output_pkg::*;

    localparam logic [7:0] CTRL_A = CTRL_INDEX << INDEX_SHIFT;
    localparam logic [7:0] STATUS_A = STATUS_INDEX << INDEX_SHIFT;
    // pclk cycles per period: crystal half-period is 4 cycles, low-frequency period 100
    localparam int PER_TAB [8] = '{8, 16, 24, 60, 80, 120, 240, 100};
    localparam int TAIL_TAB [4] = '{0, 128, 256, 512};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        xtal_clk_in, lf_clk_in, sleep_cmd, irq_pending, irq_read;
    logic        clock_output_pin, xtal_osc_en, sleep_entered;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] period, edge_cnt, c0, base;
    int          num_errors, checks;

    mcu_clock_output i_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .xtal_clk_in, .lf_clk_in, .sleep_cmd, .irq_pending, .clock_output_pin, .xtal_osc_en, .sleep_entered
    );

    mcu_model i_mcu
    (
        .pclk, .mcu_clk(clock_output_pin), .irq_pending, .irq_read, .period, .edge_cnt
    );

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // source edges sit 1 ns off the pclk grid
    initial
    begin
        xtal_clk_in = 1'b0;
        lf_clk_in   = 1'b0;
        #1;
        fork
            forever #200 lf_clk_in = ~lf_clk_in;
            forever
            begin
                #16;
                if (xtal_osc_en !== 1'b0)
                    xtal_clk_in = ~xtal_clk_in;
            end
        join
    end

    task automatic finish_test();
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    function automatic logic hit(input int what);
        case (what)
            0: return edge_cnt >= c0;
            1: return sleep_entered === 1'b1;
            default: return irq_read === 1'b1;
        endcase
    endfunction

    task automatic wait_for(input int what, input int lim);
        for (int n = 0; n < lim && !hit(what); n++)
            @(posedge pclk);
        if (!hit(what))
        begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (pready !== 1'b1)
        begin
            num_errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // skip two edges so a rate change in progress is not measured
    task automatic rate(input int exp);
        c0 = edge_cnt + 16'h3;
        wait_for(0, 2000);
        chk("period", 32'(exp), {16'h0, period});
    endtask

    initial
    begin
        {psel, penable, pwrite, sleep_cmd, irq_pending} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_A, 32'h0);
        chk("ctrl reset", 32'h0b, rd);
        rate(PER_TAB[3]);
        apb(1'b1, 8'h30, 32'h3f);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, CTRL_A, 32'h0);
        chk("ctrl kept", 32'h0b, rd);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, CTRL_A, 32'hc8 | 32'(k));
            apb(1'b0, CTRL_A, 32'h0);
            chk("ctrl", 32'h08 | 32'(k), rd);
            rate(PER_TAB[k]);
        end
        apb(1'b1, CTRL_A, 32'h08);
        rate(PER_TAB[0]);
        sleep_cmd <= 1'b1;
        rate(PER_TAB[7]);
        chk("xtal in sleep", 32'h0, {31'h0, xtal_osc_en});
        sleep_cmd <= 1'b0;
        rate(PER_TAB[0]);
        for (int t = 0; t < 4; t++)
        begin
            apb(1'b1, CTRL_A, 32'(t) << 4);
            rate(PER_TAB[0]);
            base = edge_cnt;
            sleep_cmd <= 1'b1;
            wait_for(1, 6000);
            chk("tail min", 32'h1, {31'h0, (edge_cnt - base) >= TAIL_TAB[t]});
            chk("tail max", 32'h1, {31'h0, (edge_cnt - base) <= TAIL_TAB[t] + 1});
            c0 = edge_cnt;
            repeat (40) @(posedge pclk);
            chk("stopped edges", {16'h0, c0}, {16'h0, edge_cnt});
            chk("stopped pin", 32'h0, {31'h0, clock_output_pin});
            apb(1'b0, STATUS_A, 32'h0);
            chk("status asleep", 32'h01, rd);
            sleep_cmd <= 1'b0;
        end
        apb(1'b1, CTRL_A, 32'h0);
        irq_pending <= 1'b1;
        sleep_cmd   <= 1'b1;
        wait_for(2, 2000);
        chk("held awake", 32'h0, {31'h0, sleep_entered});
        irq_pending <= 1'b0;
        wait_for(1, 200);
        sleep_cmd <= 1'b0;
        rate(PER_TAB[0]);
        finish_test();
    end
endmodule

`default_nettype wire
